// ==== ppp_pkg.sv ====
// constants for the programmable parallel port slave
//
// Contract
// - fifo mode read data appears exactly two link clocks after read strobe asserts.
// - fifo flag reflects a write exactly three link clocks after write strobe asserts.
// - data and flags follow a fifo address change three clocks later; master waits.
// - fifo mode data bus driven only while output-drive strobe is low, released otherwise.
// - processor and device launch and sample on the same link clock edge.
// - mux read ready asserts two cycles after oe, drops one cycle after data.
// - mux read data valid two cycles after oe, held until oe deasserts.
// - mux write ready two cycles after we, drops three cycles after data sample.
// - two-cycle mux latency holds over full rate; reduced latency not supported.
// - async non-ddr data latch closes on strobe deasserting edge.
package ppp_pkg;
  localparam int DATA_W      = 32;
  localparam int ADDR_W      = 2;
  localparam int NUM_FIFO    = 4;
  localparam int FIFO_DEPTH  = 16;
  localparam int PTR_W       = 4;
  localparam int CNT_W       = 5;
  localparam int READ_LAT    = 2;
  localparam int FLAG_LAT    = 3;
  localparam int ADDR_LAT    = 3;
  localparam int MUX_LAT     = 2;
  localparam int MUX_WR_DROP = 3;
  typedef enum logic [1:0] {mux_idle, mux_read, mux_write, mux_wdone} mux_state_t;
endpackage

// ==== ppp_async_latch.sv ====
`timescale 1ns/1ps
// transparent latch for async non-ddr data capture
module ppp_async_latch (
  // latch strobe, active high
  input  wire logic                        data_latch_strobe,
  // bus input
  input  wire logic [ppp_pkg::DATA_W-1:0]  din,
  // held value
  output logic      [ppp_pkg::DATA_W-1:0]  dout
);
  // transparent while strobe high; closes on the falling (deasserting) edge
  always_latch begin
    if (data_latch_strobe) begin
      dout <= din;
    end
  end
endmodule

// ==== ppp_port.sv ====
`timescale 1ns/1ps
// synchronous slave fifo and address/data multiplexed port of the parallel slave
module ppp_port (
  // system side
  input  wire logic                           clk,
  input  wire logic                           reset,
  // link clock from master
  input  wire logic                           link_clk,
  // mode: 0 slave fifo, 1 multiplexed processor
  input  wire logic                           mux_mode,
  // slave fifo strobes, active low
  input  wire logic                           fifo_read_strobe_n,
  input  wire logic                           fifo_write_strobe_n,
  input  wire logic                           fifo_output_drive_n,
  input  wire logic [ppp_pkg::ADDR_W-1:0]     fifo_addr,
  // multiplexed mode strobes, active low
  input  wire logic                           mux_oe_n,
  input  wire logic                           mux_we_n,
  // shared data pins
  input  wire logic [ppp_pkg::DATA_W-1:0]     dq_in,
  output logic      [ppp_pkg::DATA_W-1:0]     dq_out,
  output logic                                dq_oe,
  // flags and ready
  output logic                                fifo_flag,
  output logic                                mux_ready,
  // async latch path
  input  wire logic                           data_latch_strobe,
  output logic      [ppp_pkg::DATA_W-1:0]     latched_data,
  // system-side view of accepted fifo writes, synchronised to clk
  output logic                                link_active
);
  localparam int NF = ppp_pkg::NUM_FIFO;

  // async latch path lives outside both clock domains
  ppp_async_latch u_latch (
    .data_latch_strobe (data_latch_strobe),
    .din               (dq_in),
    .dout              (latched_data)
  );

  typedef struct packed {
    logic                                  rd_n;
    logic                                  wr_n;
    logic                                  oe_n;
    logic                                  moe_n;
    logic                                  mwe_n;
    logic [ppp_pkg::ADDR_W-1:0]            addr;
    logic [ppp_pkg::DATA_W-1:0]            wdata;
    logic [ppp_pkg::READ_LAT-2:0]          rd_pipe;
    logic                                  room;
    logic [ppp_pkg::ADDR_LAT-2:0][ppp_pkg::ADDR_W-1:0] addr_pipe;
    logic [NF-1:0][ppp_pkg::PTR_W-1:0]     wptr;
    logic [NF-1:0][ppp_pkg::PTR_W-1:0]     rptr;
    logic [NF-1:0][ppp_pkg::CNT_W-1:0]     count;
    logic [ppp_pkg::DATA_W-1:0]            dout;
    logic                                  flag;
    ppp_pkg::mux_state_t                   mst;
    logic [1:0]                            mcnt;
    logic                                  ready;
    logic                                  act_tgl;
  } link_state_t;

  link_state_t st;
  link_state_t next_st;
  logic [ppp_pkg::DATA_W-1:0] mem [NF][ppp_pkg::FIFO_DEPTH];
  logic [ppp_pkg::DATA_W-1:0] mux_reg;
  logic                       mem_we;

  // reset crossed into the link domain through two flops
  logic [1:0] link_rst_sync;
  logic       link_rst;
  always_ff @(posedge link_clk) begin
    link_rst_sync <= {link_rst_sync[0], reset};
  end
  assign link_rst = link_rst_sync[1];

  function automatic logic fifo_has_room(input logic [ppp_pkg::CNT_W-1:0] c);
    return c != ppp_pkg::CNT_W'(ppp_pkg::FIFO_DEPTH);
  endfunction

  // next-state logic in the link domain; every launch/sample on rising edge
  always_comb begin
    next_st = st;
    mem_we  = 1'b0;
    // inputs registered first, strobes active low
    next_st.rd_n  = fifo_read_strobe_n;
    next_st.wr_n  = fifo_write_strobe_n;
    next_st.oe_n  = fifo_output_drive_n;
    next_st.moe_n = mux_oe_n;
    next_st.mwe_n = mux_we_n;
    next_st.addr  = fifo_addr;
    next_st.wdata = dq_in;
    // address pipe: selected fifo changes ADDR_LAT cycles after the pins
    next_st.addr_pipe = {st.addr_pipe[ppp_pkg::ADDR_LAT-3:0], st.addr};
    // read strobe pipe: the registered strobe is the first stage, so the
    // word is launched on the READ_LAT-th edge after the strobe is taken
    next_st.rd_pipe[ppp_pkg::READ_LAT-2] = !mux_mode && !st.rd_n;
    if (!mux_mode && st.rd_pipe[ppp_pkg::READ_LAT-2]) begin
      // an empty fifo leaves the last word on the bus and its pointer still
      if (st.count[st.addr_pipe[ppp_pkg::ADDR_LAT-2]] != '0) begin
        next_st.dout = mem[st.addr_pipe[ppp_pkg::ADDR_LAT-2]]
                          [st.rptr[st.addr_pipe[ppp_pkg::ADDR_LAT-2]]];
        next_st.rptr[st.addr_pipe[ppp_pkg::ADDR_LAT-2]] =
          st.rptr[st.addr_pipe[ppp_pkg::ADDR_LAT-2]] + 1'b1;
        next_st.count[st.addr_pipe[ppp_pkg::ADDR_LAT-2]] =
          st.count[st.addr_pipe[ppp_pkg::ADDR_LAT-2]] - 1'b1;
      end
    end
    // writes store on the edge after the registered strobe
    if (!mux_mode && !st.wr_n && fifo_has_room(st.count[st.addr])) begin
      mem_we = 1'b1;
      next_st.wptr[st.addr]  = st.wptr[st.addr] + 1'b1;
      next_st.count[st.addr] = next_st.count[st.addr] + 1'b1;
      next_st.act_tgl        = ~st.act_tgl;
    end
    // room is judged one edge after the count moves and shown one edge later,
    // which puts the flag three edges after the strobe or address is taken
    next_st.room = fifo_has_room(st.count[st.addr_pipe[ppp_pkg::ADDR_LAT-3]]);
    next_st.flag = st.room;
    // multiplexed processor handshake, fixed two-cycle latency at all rates
    case (st.mst)
      ppp_pkg::mux_idle: begin
        next_st.ready = 1'b0;
        next_st.mcnt  = '0;
        if (mux_mode && !st.moe_n) begin
          next_st.mst  = ppp_pkg::mux_read;
          next_st.mcnt = 2'd1;
        end else if (mux_mode && !st.mwe_n) begin
          next_st.mst  = ppp_pkg::mux_write;
          next_st.mcnt = 2'd1;
        end
      end
      ppp_pkg::mux_read: begin
        // data and ready two cycles after oe; ready dropped after one cycle
        if (st.mcnt == 2'(ppp_pkg::MUX_LAT - 1)) begin
          next_st.dout  = mux_reg;
          next_st.ready = 1'b1;
          next_st.mcnt  = st.mcnt + 1'b1;
        end else if (st.mcnt != '0 && st.mcnt < 2'(ppp_pkg::MUX_LAT - 1)) begin
          next_st.mcnt = st.mcnt + 1'b1;
        end else begin
          next_st.ready = 1'b0;
        end
        if (mux_oe_n) begin
          next_st.mst = ppp_pkg::mux_idle;
        end
      end
      ppp_pkg::mux_write: begin
        if (st.mcnt == 2'(ppp_pkg::MUX_LAT - 1)) begin
          next_st.ready = 1'b1;
          next_st.mcnt  = st.mcnt + 1'b1;
        end else if (st.mcnt < 2'(ppp_pkg::MUX_LAT - 1)) begin
          next_st.mcnt = st.mcnt + 1'b1;
        end else begin
          // ready high: this edge samples write data
          next_st.mst  = ppp_pkg::mux_wdone;
          next_st.mcnt = '0;
        end
      end
      ppp_pkg::mux_wdone: begin
        // ready drops three cycles after the sampling edge
        next_st.mcnt = st.mcnt + 1'b1;
        if (st.mcnt == 2'(ppp_pkg::MUX_WR_DROP - 1)) begin
          next_st.ready = 1'b0;
          next_st.mst   = ppp_pkg::mux_idle;
        end
      end
      default: begin
        next_st.mst = ppp_pkg::mux_idle;
      end
    endcase
  end

  // link-domain registers
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      st       <= '0;
      st.rd_n  <= 1'b1;
      st.wr_n  <= 1'b1;
      st.oe_n  <= 1'b1;
      st.moe_n <= 1'b1;
      st.mwe_n <= 1'b1;
      st.flag  <= 1'b1;
      st.room  <= 1'b1; // no false flag drop on the first edge out of reset
      st.mst   <= ppp_pkg::mux_idle;
    end else begin
      st <= next_st;
    end
  end

  // fifo storage and the single processor-mode data word
  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      mem[st.addr][st.wptr[st.addr]] <= st.wdata;
    end
    if (st.mst == ppp_pkg::mux_write && st.ready) begin
      mux_reg <= st.wdata;
    end
  end

  // bus drive gated by the pin itself so release is immediate on deassert
  assign dq_oe  = mux_mode ? (st.mst == ppp_pkg::mux_read && !mux_oe_n)
                           : !fifo_output_drive_n;
  assign dq_out = st.dout;
  assign fifo_flag = st.flag;
  assign mux_ready = st.ready;

  // write activity toggle crosses to clk with two flops then an edge detect
  logic [2:0] act_sync;
  always_ff @(posedge clk) begin
    if (reset) begin
      act_sync <= '0;
    end else begin
      act_sync <= {act_sync[1:0], st.act_tgl};
    end
  end
  assign link_active = act_sync[2] ^ act_sync[1];
endmodule

// ==== ppp_port_assertions.sv ====
`timescale 1ns/1ps
// concurrent timing checks on the parallel slave port pins
module ppp_port_assertions (
  // clocks and reset
  input wire logic                       clk,
  input wire logic                       reset,
  input wire logic                       link_clk,
  // master side
  input wire logic                       mux_mode,
  input wire logic                       fifo_read_strobe_n,
  input wire logic                       fifo_write_strobe_n,
  input wire logic                       fifo_output_drive_n,
  input wire logic [ppp_pkg::ADDR_W-1:0] fifo_addr,
  input wire logic                       mux_oe_n,
  input wire logic                       mux_we_n,
  input wire logic [ppp_pkg::DATA_W-1:0] dq_in,
  // device side
  input wire logic [ppp_pkg::DATA_W-1:0] dq_out,
  input wire logic                       dq_oe,
  input wire logic                       fifo_flag,
  input wire logic                       mux_ready,
  input wire logic                       data_latch_strobe,
  input wire logic [ppp_pkg::DATA_W-1:0] latched_data
);
  // ready seen for one beat on a read, four on a write
  sequence rd_ack;
    mux_ready ##1 !mux_ready;
  endsequence
  sequence wr_ack;
    mux_ready [*4] ##1 !mux_ready;
  endsequence
  // dq_out, fifo_flag and mux_ready are registered, so a change is seen one edge after it is launched
  chk_fifo_read_lat: assert property (@(posedge link_clk) disable iff (reset)
    !mux_mode && $changed(dq_out) |-> !$past(fifo_read_strobe_n, 3)) else $error("data moved");
  chk_flag_goes_full: assert property (@(posedge link_clk) disable iff (reset)
    $fell(fifo_flag) |-> !$past(fifo_write_strobe_n, 4) || $past(fifo_addr, 4) != $past(fifo_addr, 5))
    else $error("flag fell without cause");
  chk_drive_only_oe: assert property (@(posedge link_clk) disable iff (reset)
    !mux_mode |-> dq_oe == !fifo_output_drive_n) else $error("bus drive wrong");
  chk_mux_rd_ready: assert property (@(posedge link_clk) disable iff (reset)
    mux_mode && $fell(mux_oe_n) |-> ##3 rd_ack) else $error("read ready timing");
  chk_mux_rd_hold: assert property (@(posedge link_clk) disable iff (reset)
    mux_mode && !(mux_oe_n || $past(mux_oe_n) || $past(mux_oe_n, 2) || $past(mux_oe_n, 3)
    || $past(mux_oe_n, 4)) |-> $stable(dq_out)) else $error("read data not held");
  chk_mux_wr_ready: assert property (@(posedge link_clk) disable iff (reset)
    mux_mode && $fell(mux_we_n) |-> ##3 wr_ack) else $error("write ready timing");
  chk_ready_cause: assert property (@(posedge link_clk) disable iff (reset)
    $rose(mux_ready) |-> !$past(mux_oe_n, 3) || !$past(mux_we_n, 3)) else $error("stray ready");
  chk_latch_closed: assert property (@(posedge clk) disable iff (reset)
    !data_latch_strobe && !$past(data_latch_strobe) |-> $stable(latched_data))
    else $error("closed latch moved");
  chk_latch_open: assert property (@(posedge clk) disable iff (reset)
    data_latch_strobe |-> latched_data == dq_in) else $error("open latch not passing");
endmodule
bind ppp_port ppp_port_assertions i_ppp_port_assertions (.clk(clk), .reset(reset),
  .link_clk(link_clk), .mux_mode(mux_mode), .fifo_read_strobe_n(fifo_read_strobe_n),
  .fifo_write_strobe_n(fifo_write_strobe_n), .fifo_output_drive_n(fifo_output_drive_n),
  .fifo_addr(fifo_addr), .mux_oe_n(mux_oe_n), .mux_we_n(mux_we_n), .dq_in(dq_in),
  .dq_out(dq_out), .dq_oe(dq_oe), .fifo_flag(fifo_flag), .mux_ready(mux_ready),
  .data_latch_strobe(data_latch_strobe), .latched_data(latched_data));

// ==== ppp_master_model.sv ====
`timescale 1ns/1ps
// master-side model: interface clock and the shared data wires
module ppp_master_model (
  // interface clock toward the slave
  output logic                             link_clk,
  // device side of the data pins
  input  wire logic [ppp_pkg::DATA_W-1:0]  dq_out,
  input  wire logic                        dq_oe,
  // level the master sees on the wires
  output logic      [ppp_pkg::DATA_W-1:0]  bus_level
);
  // free running, offset so it has no phase tie to the system clock
  initial begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end
  // a released wire must not look like it still holds the last word
  assign bus_level = dq_oe ? dq_out : ~dq_out;
endmodule

// ==== ppp_port_bench.sv ====
`timescale 1ns/1ps
// self-checking bench for the parallel slave port
module ppp_port_bench;
  logic                       clk = 1'b0, reset = 1'b1, link_clk, mux_mode = 1'b0, dls = 1'b1;
  logic                       act;
  logic                       rd_n = 1'b1, wr_n = 1'b1, oe_n = 1'b1, moe_n = 1'b1, mwe_n = 1'b1;
  logic [ppp_pkg::DATA_W-1:0] dq_in = 32'h0, dq_out, bus, ld, w[17];
  logic [ppp_pkg::ADDR_W-1:0] addr = 2'h0;
  logic                       dq_oe, flag, rdy;
  int                         fails = 0, samples_checked = 0, cycles = 0, act_pulses = 0;
  always #10 clk = ~clk;
  ppp_master_model i_ppp_master_model (.link_clk(link_clk), .dq_out(dq_out), .dq_oe(dq_oe),
    .bus_level(bus));
  ppp_port i_ppp_port (.clk(clk), .reset(reset), .link_clk(link_clk), .mux_mode(mux_mode),
    .fifo_read_strobe_n(rd_n), .fifo_write_strobe_n(wr_n), .fifo_output_drive_n(oe_n),
    .fifo_addr(addr), .mux_oe_n(moe_n), .mux_we_n(mwe_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .fifo_flag(flag), .mux_ready(rdy), .data_latch_strobe(dls),
    .latched_data(ld), .link_active(act));
  // room remains until the depth is reached
  function automatic logic flag_after(int n);
    return n < ppp_pkg::FIFO_DEPTH;
  endfunction
  // an empty fifo repeats the last word it gave
  function automatic logic [31:0] rd_exp(int k);
    return w[k < ppp_pkg::FIFO_DEPTH ? k : ppp_pkg::FIFO_DEPTH - 1];
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      results();
    end
  end
  // accepted fifo writes, seen as pulses in the system clock domain
  always @(posedge clk) begin
    if (act === 1'b1) act_pulses++;
  end
  initial begin
    void'($urandom(32'h24DD));
    foreach (w[i]) w[i] = $urandom();
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // latch was open during reset so it never holds an unknown word
    dls <= 1'b0;
    repeat (6) @(posedge link_clk);
    // seventeen back-to-back writes, the last meets a full fifo
    for (int i = 0; i < 20; i++) begin
      @(posedge link_clk);
      wr_n <= (i > 16);
      dq_in <= (i > 16) ? ~w[16] : w[i];
      @(negedge link_clk);
      if (i > 3) chk("flag", flag_after(i - 3), flag);
    end
    // select an empty fifo: its flag shows three edges later
    for (int i = 0; i < 5; i++) begin
      @(posedge link_clk);
      addr <= 2'h1;
      @(negedge link_clk);
      if (i > 0) chk("flag after select", i > 3, flag);
    end
    @(posedge link_clk);
    addr <= 2'h0;
    oe_n <= 1'b0;
    repeat (4) @(posedge link_clk);
    // read past the end, on the wires the master sees
    for (int i = 0; i < 20; i++) begin
      @(posedge link_clk);
      rd_n <= (i > 16);
      @(negedge link_clk);
      if (i > 2) chk("read word", rd_exp(i - 3), bus);
    end
    @(posedge link_clk);
    oe_n <= 1'b1;
    @(negedge link_clk);
    chk("bus released", 0, dq_oe);
    @(posedge link_clk);
    mux_mode <= 1'b1;
    @(posedge link_clk);
    mwe_n <= 1'b0;
    dq_in <= w[3];
    for (int n = 0; n < 10 && rdy !== 1'b1; n++) @(posedge link_clk);
    chk("mux write ready", 1, rdy);
    mwe_n <= 1'b1;
    dq_in <= ~w[3];
    repeat (8) @(posedge link_clk);
    moe_n <= 1'b0;
    repeat (3) @(posedge link_clk);
    @(negedge link_clk);
    chk("mux data", w[3], dq_out);
    chk("mux ready", 1, rdy);
    @(posedge link_clk);
    moe_n <= 1'b1;
    @(posedge clk);
    dls <= 1'b1;
    dq_in <= w[5];
    @(posedge clk);
    dls <= 1'b0;
    @(posedge clk);
    dq_in <= w[6];
    @(negedge clk);
    chk("latch", w[5], ld);
    chk("write pulses", ppp_pkg::FIFO_DEPTH, act_pulses);
    results();
  end
endmodule
